// ---- design/fp_context_control_regs.sv ----
// fp context control, default status control and fp status/control access rules
//
// What this block does
// [R01] treat-as-secure zero: fp registers non-secure, callee-saved registers never pushed.
// [R02] treat-as-secure reads zero from non-secure, ignores writes, warm reset clears it.
// [R03] bit 10 captures usage-fault pend capability, banked, unknown reset.
// [R04] stack limit violation skips lazy memory accesses but secure state still zeroed.
// [R05] bit 8 debug-monitor capability, unbanked, hidden from non-secure when monitor secure.
// [R06] bit 7 secure-fault capability, secure view only, non-secure reads zero.
// [R07] bits 6 and 4 hidden from non-secure unless faults target non-secure.
// [R08] bit 5 memmanage capability, banked per security state, unknown reset.
// [R09] bit 3 captures thread mode, banked, has no effect on exceptions.
// [R10] bit 2 context security updated on lazy activation or fp instruction, resets one.
// [R11] bit 1 captures unprivileged, banked, unknown reset.
// [R12] bit 0 lazy preservation active, banked, clears on warm reset.
// [R13] default register values copied into fp status/control on new context.
// [R14] default fields at 26, 25, 24, 23:22, reset zero, others zero.
// [R15] default register at the documented address, 32-bit read/write, banked.
// [R16] unprivileged non-debugger access faults; only privileged or debugger word accesses are served.
// [R17] non-secure alias readable by secure software only, else zero.
// [R18] fp status/control unbanked; unprivileged reads zero, writes ignored.
// [R19] fp status/control write effects visible only to later instructions.
// [R20] rounding encodings: nearest, plus infinity, minus infinity, zero.
// [R21] context control register at its documented 32-bit address.
// [R22] context control bits 25 to 11 read zero and ignore writes.
`timescale 1ns/10ps
module fp_context_control_regs
	import fp_ctx_pkg::*;
#(
	parameter int addr_width = 32
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// memory-mapped register port
	input wire logic req,
	input wire logic write,
	input wire logic [addr_width-1:0] addr,
	input wire logic [1:0] size,
	input wire logic [31:0] wdata,
	input wire logic req_secure,
	input wire logic req_privileged,
	input wire logic req_debugger,
	output logic [31:0] rdata,
	output logic ack,
	output logic bus_fault,
	// special register port for fp status/control
	input wire logic sr_req,
	input wire logic sr_write,
	input wire logic sr_privileged,
	input wire logic [31:0] sr_wdata,
	output logic [31:0] sr_rdata,
	// system controls
	input wire logic secure_debug_monitor_enable,
	input wire logic faults_target_nonsecure,
	// core events
	input wire logic frame_alloc,
	input wire logic frame_secure,
	input wire frame_capture_s frame_info,
	input wire logic lazy_activate,
	input wire logic lazy_done,
	input wire logic fp_instr,
	input wire logic cur_secure,
	input wire logic new_context,
	input wire logic new_context_secure,
	input wire logic [31:0] fpu_status_next,
	input wire logic fpu_status_update,
	// derived outputs
	output logic fp_regs_secure,
	output logic push_callee_fp,
	output logic lazy_skip_memory,
	output logic lazy_zero_regs,
	output logic [31:0] fp_status_and_control
);

	initial begin
		if (addr_width != 32) $error("addr_width must be 32");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic treat_as_secure;
	logic ctx_secure;
	logic debug_monitor_pend_capable;
	logic secure_fault_pend_capable;
	logic bus_fault_pend_capable;
	logic hard_fault_pend_capable;
	logic [1:0] usage_fault_pend_capable;
	logic [1:0] stack_limit_violation;
	logic [1:0] memmanage_pend_capable;
	logic [1:0] thread_mode;
	logic [1:0] unprivileged;
	logic [1:0] lazy_preserve_active;
	fp_defaults_s fp_default_status_control [2]; // see [R20]
	access_state_e acc_state;

	// index 1 is the secure bank, 0 the non-secure
	function automatic logic [31:0] ctx_view(input logic bank, input logic sec_caller);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[usage_fault_pos] = usage_fault_pend_capable[bank]; // see [R03]
		v[stack_limit_pos] = stack_limit_violation[bank];
		v[memmanage_pos] = memmanage_pend_capable[bank]; // see [R08]
		v[thread_pos] = thread_mode[bank]; // see [R09]
		v[user_pos] = unprivileged[bank]; // see [R11]
		v[lazy_active_pos] = lazy_preserve_active[bank]; // see [R12]
		v[debug_monitor_pos] = (sec_caller || !secure_debug_monitor_enable) && debug_monitor_pend_capable; // see [R05]
		v[bus_fault_pos] = (sec_caller || faults_target_nonsecure) && bus_fault_pend_capable; // see [R07]
		v[hard_fault_pos] = (sec_caller || faults_target_nonsecure) && hard_fault_pend_capable; // see [R07]
		if (sec_caller) begin
			v[treat_as_secure_pos] = treat_as_secure; // see [R02]
			v[secure_fault_pos] = secure_fault_pend_capable; // see [R06]
			v[ctx_secure_pos] = ctx_secure; // see [R10]
		end
		return v; // bits 25..11 stay zero, see [R22]
	endfunction : ctx_view

	function automatic logic [31:0] dflt_view(input fp_defaults_s d);
		return {5'h00, d, 22'h000000} & dflt_mask; // see [R14]
	endfunction : dflt_view

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic hit_ctx, hit_ctx_ns, hit_dflt, hit_dflt_ns;
	logic alias_ok, word_ok, priv_fault, do_write;
	logic wr_ctx, wr_dflt, sel_bank, nonsec_wr;

	assign hit_ctx = (addr == ctx_ctrl_addr); // see [R21]
	assign hit_ctx_ns = (addr == ctx_ctrl_ns_addr);
	assign hit_dflt = (addr == dflt_addr); // see [R15]
	assign hit_dflt_ns = (addr == dflt_ns_addr);
	// aliases exist only for secure software, debugger sees zero
	assign alias_ok = req_secure && !req_debugger; // see [R17]
	assign word_ok = (size == 2'h2); // see [R16]
	// a debugger access is never treated as unprivileged
	assign priv_fault = req && !req_privileged && !req_debugger &&
		(hit_ctx || hit_ctx_ns || hit_dflt || hit_dflt_ns); // see [R16]
	assign do_write = req && write && !priv_fault && word_ok;
	assign wr_ctx = do_write && (hit_ctx || (hit_ctx_ns && alias_ok));
	assign wr_dflt = do_write && (hit_dflt || (hit_dflt_ns && alias_ok));
	assign sel_bank = (hit_ctx || hit_dflt) ? req_secure : 1'b0;
	assign nonsec_wr = !(req_secure && (hit_ctx || hit_dflt));

	// ----------------------------------------
	// bus answer, one cycle after request
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_state <= acc_idle;
			rdata <= 32'h0000_0000;
		end else begin
			case (acc_state)
				acc_idle, acc_done, acc_fault: begin
					if (priv_fault) begin
						acc_state <= acc_fault;
						rdata <= 32'h0000_0000;
					end else if (req) begin
						acc_state <= acc_done;
						if (write || !word_ok) rdata <= 32'h0000_0000;
						else if (hit_ctx) rdata <= ctx_view(req_secure, req_secure);
						else if (hit_dflt) rdata <= dflt_view(fp_default_status_control[req_secure]);
						else if (hit_ctx_ns && alias_ok) rdata <= ctx_view(1'b0, 1'b0);
						else if (hit_dflt_ns && alias_ok) rdata <= dflt_view(fp_default_status_control[0]); // see [R17]
						else rdata <= 32'h0000_0000;
					end else begin
						acc_state <= acc_idle;
					end
				end
				default: acc_state <= acc_idle;
			endcase
		end
	end

	assign ack = (acc_state != acc_idle);
	assign bus_fault = (acc_state == acc_fault); // see [R16]

	// ----------------------------------------
	// unbanked secure-side bits
	// ----------------------------------------
	// frame capture beats a same-cycle write, so software cannot mask a capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			treat_as_secure <= treat_as_secure_rst; // see [R02]
			secure_fault_pend_capable <= captured_rst;
			debug_monitor_pend_capable <= captured_rst;
			bus_fault_pend_capable <= captured_rst;
			hard_fault_pend_capable <= captured_rst;
		end else if (frame_alloc) begin
			secure_fault_pend_capable <= frame_info.secure_fault_pend_capable;
			debug_monitor_pend_capable <= frame_info.debug_monitor_pend_capable;
			bus_fault_pend_capable <= frame_info.bus_fault_pend_capable;
			hard_fault_pend_capable <= frame_info.hard_fault_pend_capable;
		end else if (wr_ctx) begin
			if (!nonsec_wr) begin
				treat_as_secure <= wdata[treat_as_secure_pos]; // see [R02]
				secure_fault_pend_capable <= wdata[secure_fault_pos]; // see [R06]
			end
			if (!nonsec_wr || !secure_debug_monitor_enable)
				debug_monitor_pend_capable <= wdata[debug_monitor_pos]; // see [R05]
			if (!nonsec_wr || faults_target_nonsecure) begin
				bus_fault_pend_capable <= wdata[bus_fault_pos]; // see [R07]
				hard_fault_pend_capable <= wdata[hard_fault_pos];
			end
		end
	end

	// ----------------------------------------
	// context security flag
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) ctx_secure <= ctx_secure_rst;
		else if (lazy_activate || fp_instr) ctx_secure <= cur_secure; // see [R10]
		else if (wr_ctx && !nonsec_wr) ctx_secure <= wdata[ctx_secure_pos];
	end

	// ----------------------------------------
	// banked capture bits
	// ----------------------------------------
	for (genvar b = 0; b < 2; b++) begin : g_bank
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				usage_fault_pend_capable[b] <= captured_rst;
				stack_limit_violation[b] <= captured_rst;
				memmanage_pend_capable[b] <= captured_rst;
				thread_mode[b] <= captured_rst;
				unprivileged[b] <= captured_rst;
			end else if (frame_alloc && frame_secure == b[0]) begin
				usage_fault_pend_capable[b] <= frame_info.usage_fault_pend_capable; // see [R03]
				stack_limit_violation[b] <= frame_info.stack_limit_violation;
				memmanage_pend_capable[b] <= frame_info.memmanage_pend_capable; // see [R08]
				thread_mode[b] <= frame_info.thread_mode; // see [R09]
				unprivileged[b] <= frame_info.unprivileged; // see [R11]
			end else if (wr_ctx && sel_bank == b[0]) begin
				usage_fault_pend_capable[b] <= wdata[usage_fault_pos];
				stack_limit_violation[b] <= wdata[stack_limit_pos];
				memmanage_pend_capable[b] <= wdata[memmanage_pos];
				thread_mode[b] <= wdata[thread_pos];
				unprivileged[b] <= wdata[user_pos];
			end
		end

		// hardware set/clear wins over a software write
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) lazy_preserve_active[b] <= lazy_active_rst; // see [R12]
			else if (lazy_activate && frame_secure == b[0]) lazy_preserve_active[b] <= 1'b1; // see [R12]
			else if (lazy_done && frame_secure == b[0]) lazy_preserve_active[b] <= 1'b0;
			else if (wr_ctx && sel_bank == b[0]) lazy_preserve_active[b] <= wdata[lazy_active_pos];
		end

		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) fp_default_status_control[b] <= fp_defaults_s'(dflt_rst); // see [R14]
			else if (wr_dflt && sel_bank == b[0])
				fp_default_status_control[b] <= fp_defaults_s'(wdata[flush_pos+2:rounding_select_lo_pos]); // see [R15]
		end
	end

	// ----------------------------------------
	// fp status and control
	// ----------------------------------------
	// single unbanked copy; a write lands at the edge so only later instructions see it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) fp_status_and_control <= 32'h0000_0000;
		else if (new_context)
			fp_status_and_control <= dflt_view(fp_default_status_control[new_context_secure]); // see [R13]
		else if (sr_req && sr_write && sr_privileged) fp_status_and_control <= sr_wdata; // see [R18] [R19]
		else if (fpu_status_update) fp_status_and_control <= fpu_status_next;
	end

	assign sr_rdata = (sr_req && sr_privileged) ? fp_status_and_control : 32'h0000_0000; // see [R18]

	// ----------------------------------------
	// lazy preservation steering
	// ----------------------------------------
	assign fp_regs_secure = cur_secure && treat_as_secure; // see [R01]
	assign push_callee_fp = fp_regs_secure; // see [R01]
	assign lazy_skip_memory = stack_limit_violation[ctx_secure]; // see [R04]
	assign lazy_zero_regs = ctx_secure && treat_as_secure; // see [R04]

	// ----------------------------------------
	// checks
	// ----------------------------------------
	no_push_clear_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R01]
		!treat_as_secure |-> !push_callee_fp && !fp_regs_secure) else $error("callee push while not secure");
	tas_ns_wi_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R02]
		(wr_ctx && nonsec_wr) |=> $stable(treat_as_secure)) else $error("treat-as-secure changed by non-secure write");
	sf_ns_raz_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R06]
		(req && !write && hit_ctx && !req_secure && !priv_fault && word_ok)
		|=> rdata[secure_fault_pos] == 1'b0 && rdata[treat_as_secure_pos] == 1'b0) else $error("secure bit leaked");
	bf_hidden_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R07]
		(req && !write && hit_ctx && !req_secure && !faults_target_nonsecure && !priv_fault && word_ok)
		|=> rdata[bus_fault_pos] == 1'b0 && rdata[hard_fault_pos] == 1'b0) else $error("fault bits leaked");
	ctx_sec_upd_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R10]
		fp_instr |=> ctx_secure == $past(cur_secure)) else $error("context security not updated");
	lazy_set_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R12]
		(lazy_activate && frame_secure) |=> lazy_preserve_active[1]) else $error("lazy flag not set");
	unpriv_fault_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R16]
		(req && !req_privileged && !req_debugger && hit_dflt) |=> bus_fault && ack) else $error("no bus fault");
	alias_ns_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R17]
		(req && !write && hit_dflt_ns && !req_secure) |=> rdata == 32'h0000_0000) else $error("alias visible");
	newctx_copy_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R13]
		(new_context && !new_context_secure) |=> fp_status_and_control[31:27] == 5'h00 &&
		fp_status_and_control[21:0] == 22'h000000) else $error("default copy wrong");
	sr_unpriv_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R18]
		(sr_req && !sr_privileged) |-> sr_rdata == 32'h0000_0000) else $error("unprivileged read");

	// read views are sampled the cycle after the request is taken
	dm_ns_hidden_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R05]
		(req && !write && hit_ctx && !req_secure && secure_debug_monitor_enable && !priv_fault && word_ok)
		|=> rdata[debug_monitor_pos] == 1'b0) else $error("monitor bit leaked");
	ctx_sec_hidden_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R10]
		(req && !write && hit_ctx && !req_secure && !priv_fault && word_ok)
		|=> rdata[ctx_secure_pos] == 1'b0) else $error("context security bit leaked");
	ctx_rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R22]
		(req && !write && (hit_ctx || hit_ctx_ns))
		|=> rdata[treat_as_secure_pos-1:usage_fault_pos+1] == 15'h0000) else $error("reserved bits set");
	dflt_rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R14]
		(req && !write && (hit_dflt || hit_dflt_ns))
		|=> (rdata & ~dflt_mask) == 32'h0000_0000) else $error("default reserved bits set");
	alias_dbg_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R17]
		(req && !write && hit_dflt_ns && req_debugger)
		|=> rdata == 32'h0000_0000) else $error("alias visible to debugger");
	lazy_clr_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R12]
		(lazy_done && !lazy_activate && frame_secure)
		|=> !lazy_preserve_active[1]) else $error("lazy flag not cleared");
	mm_capture_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R08]
		(frame_alloc && frame_secure)
		|=> memmanage_pend_capable[1] == $past(frame_info.memmanage_pend_capable)) else $error("capture missed");
	bank_apart_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R03]
		(frame_alloc && frame_secure && !wr_ctx)
		|=> $stable(usage_fault_pend_capable[0])) else $error("other bank disturbed");
	sr_unpriv_wi_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R18]
		(sr_req && sr_write && !sr_privileged && !new_context && !fpu_status_update)
		|=> $stable(fp_status_and_control)) else $error("unprivileged write landed");
	sr_next_edge_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R19]
		(sr_req && sr_write && sr_privileged && !new_context)
		|=> fp_status_and_control == $past(sr_wdata)) else $error("status write not visible");
	ack_answer_a: assert property (@(posedge mclk) disable iff (!rstn) // see [R15]
		req |=> ack) else $error("access not answered");

endmodule : fp_context_control_regs

// ---- pkg/fp_ctx_pkg.sv ----
// package: addresses, field positions, reset values and carriers for the fp context registers
package fp_ctx_pkg;

	// ----------------------------------------
	// addresses
	// ----------------------------------------
	localparam logic [31:0] ctx_ctrl_addr = 32'he000ef34;
	localparam logic [31:0] ctx_ctrl_ns_addr = 32'he002ef34;
	localparam logic [31:0] dflt_addr = 32'he000ef3c;
	localparam logic [31:0] dflt_ns_addr = 32'he002ef3c;

	// ----------------------------------------
	// context control field positions
	// ----------------------------------------
	localparam int treat_as_secure_pos = 26;
	localparam int usage_fault_pos = 10;
	localparam int stack_limit_pos = 9;
	localparam int debug_monitor_pos = 8;
	localparam int secure_fault_pos = 7;
	localparam int bus_fault_pos = 6;
	localparam int memmanage_pos = 5;
	localparam int hard_fault_pos = 4;
	localparam int thread_pos = 3;
	localparam int ctx_secure_pos = 2;
	localparam int user_pos = 1;
	localparam int lazy_active_pos = 0;

	// ----------------------------------------
	// default status control field positions
	// ----------------------------------------
	localparam int alt_half_pos = 26;
	localparam int default_nan_pos = 25;
	localparam int flush_pos = 24;
	localparam int rounding_select_lo_pos = 22;
	localparam logic [31:0] dflt_mask = 32'h07c0_0000;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic treat_as_secure_rst = 1'b0;
	localparam logic ctx_secure_rst = 1'b1;
	localparam logic lazy_active_rst = 1'b0;
	localparam logic [4:0] dflt_rst = 5'h00;
	// bits with unknown reset are held at zero here
	localparam logic captured_rst = 1'b0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		round_nearest = 2'b00,
		round_plus_inf = 2'b01,
		round_minus_inf = 2'b10,
		round_zero = 2'b11
	} rounding_select_e;

	// snapshot taken when the fp stack frame is allocated
	typedef struct packed {
		logic usage_fault_pend_capable;
		logic debug_monitor_pend_capable;
		logic secure_fault_pend_capable;
		logic bus_fault_pend_capable;
		logic memmanage_pend_capable;
		logic hard_fault_pend_capable;
		logic thread_mode;
		logic unprivileged;
		logic stack_limit_violation;
	} frame_capture_s;

	typedef struct packed {
		logic alt_half_precision;
		logic default_nan_enable;
		logic flush_denormal_enable;
		rounding_select_e rounding_select;
	} fp_defaults_s;

	typedef enum logic [1:0] {
		acc_idle = 2'b00,
		acc_done = 2'b01,
		acc_fault = 2'b10
	} access_state_e;

endpackage : fp_ctx_pkg

// ---- tb/tb_fp_context_control_regs.sv ----
// self-checking bench for the fp context control register bank
`timescale 1ns/10ps
module tb_fp_context_control_regs
	import fp_ctx_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic mclk, rstn, req, write, req_secure, req_privileged, req_debugger;
	logic [1:0] size;
	logic [31:0] addr, wdata, rdata, sr_wdata, sr_rdata, fpu_status_next, fp_status_and_control;
	logic ack, bus_fault, sr_req, sr_write, sr_privileged;
	logic secure_debug_monitor_enable, faults_target_nonsecure;
	logic frame_alloc, frame_secure, lazy_activate, lazy_done, fp_instr, cur_secure;
	logic new_context, new_context_secure, fpu_status_update;
	logic fp_regs_secure, push_callee_fp, lazy_skip_memory, lazy_zero_regs;
	frame_capture_s frame_info;
	int n_mismatch = 0;
	int checked = 0;
	logic [31:0] rd;
	logic bf;
	typedef struct packed {
		logic w;
		logic [1:0] sz;
		logic [31:0] a, d;
		logic s, p, g;
		logic [31:0] er;
		logic ebf;
	} row_s;
	// rows run in order: later reads depend on earlier writes
	row_s rows[20] = '{
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0000_0004, 1'b0},
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, dflt_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b1, 2'h2, dflt_addr, 32'hffff_ffff, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, dflt_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h07c0_0000, 1'b0},
		'{1'b1, 2'h2, dflt_addr, 32'h0140_0000, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, dflt_ns_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0140_0000, 1'b0},
		'{1'b0, 2'h2, dflt_ns_addr, 32'h0, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, dflt_ns_addr, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0, 1'b0},
		'{1'b1, 2'h2, dflt_addr, 32'h0, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1},
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b1, 1'b0, 1'b0, 32'h0, 1'b1},
		'{1'b1, 2'h0, dflt_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, dflt_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h07c0_0000, 1'b0},
		'{1'b0, 2'h2, 32'he000_ef30, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b1, 2'h2, ctx_ctrl_addr, 32'h07ff_ffff, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0400_07ff, 1'b0},
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b0, 1'b1, 1'b0, 32'h0000_0150, 1'b0},
		'{1'b1, 2'h2, ctx_ctrl_addr, 32'h0400_0000, 1'b1, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b1, 2'h2, ctx_ctrl_addr, 32'h0000_0084, 1'b0, 1'b1, 1'b0, 32'h0, 1'b0},
		'{1'b0, 2'h2, ctx_ctrl_addr, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0400_0000, 1'b0}
	};

	fp_context_control_regs fp_context_control_regs_i (.mclk(mclk), .rstn(rstn), .req(req), .write(write),
		.addr(addr), .size(size), .wdata(wdata), .req_secure(req_secure), .req_privileged(req_privileged),
		.req_debugger(req_debugger), .rdata(rdata), .ack(ack), .bus_fault(bus_fault), .sr_req(sr_req),
		.sr_write(sr_write), .sr_privileged(sr_privileged), .sr_wdata(sr_wdata), .sr_rdata(sr_rdata),
		.secure_debug_monitor_enable(secure_debug_monitor_enable),
		.faults_target_nonsecure(faults_target_nonsecure), .frame_alloc(frame_alloc),
		.frame_secure(frame_secure), .frame_info(frame_info), .lazy_activate(lazy_activate),
		.lazy_done(lazy_done), .fp_instr(fp_instr), .cur_secure(cur_secure), .new_context(new_context),
		.new_context_secure(new_context_secure), .fpu_status_next(fpu_status_next),
		.fpu_status_update(fpu_status_update), .fp_regs_secure(fp_regs_secure),
		.push_callee_fp(push_callee_fp), .lazy_skip_memory(lazy_skip_memory),
		.lazy_zero_regs(lazy_zero_regs), .fp_status_and_control(fp_status_and_control));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task print_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// entered at a falling edge; request lasts one cycle, answer waited for under a bound
	task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
		input logic s, input logic p, input logic g);
		int i;
		req = 1'b1;
		write = w;
		size = sz;
		addr = a;
		wdata = d;
		req_secure = s;
		req_privileged = p;
		req_debugger = g;
		@(negedge mclk);
		req = 1'b0;
		for (i = 0; i < 4 && ack !== 1'b1; i++) @(negedge mclk);
		rd = rdata;
		bf = bus_fault;
		if (ack !== 1'b1) begin
			n_mismatch++;
			print_verdict;
		end else begin
			@(negedge mclk);
		end
	endtask : acc

	task automatic rd_ctx(input logic s, input logic [31:0] exp);
		acc(1'b0, 2'h2, ctx_ctrl_addr, 32'h0, s, 1'b1, 1'b0);
		chk(rd, exp);
	endtask : rd_ctx

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, req, write, size, addr, wdata, req_secure, req_privileged, req_debugger} = '0;
		{sr_req, sr_write, sr_privileged, sr_wdata, secure_debug_monitor_enable} = '0;
		{frame_alloc, frame_secure, frame_info, lazy_activate, lazy_done, fp_instr, cur_secure} = '0;
		{new_context, new_context_secure, fpu_status_next, fpu_status_update} = '0;
		faults_target_nonsecure = 1'b1;
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		for (int k = 0; k < 20; k++) begin
			acc(rows[k].w, rows[k].sz, rows[k].a, rows[k].d, rows[k].s, rows[k].p, rows[k].g);
			chk({31'h0, bf}, {31'h0, rows[k].ebf});
			if (!rows[k].w && !rows[k].ebf) chk(rd, rows[k].er);
		end
		// visibility of unbanked bits from non-secure follows the two controls
		acc(1'b1, 2'h2, ctx_ctrl_addr, 32'h0000_0150, 1'b1, 1'b1, 1'b0);
		secure_debug_monitor_enable = 1'b1;
		rd_ctx(1'b0, 32'h0000_0050);
		secure_debug_monitor_enable = 1'b0;
		faults_target_nonsecure = 1'b0;
		rd_ctx(1'b0, 32'h0000_0100);
		faults_target_nonsecure = 1'b1;
		// frame capture into the secure bank leaves the non-secure bank alone
		frame_secure = 1'b1;
		cur_secure = 1'b1;
		frame_info = '1;
		frame_alloc = 1'b1;
		@(negedge mclk);
		frame_alloc = 1'b0;
		rd_ctx(1'b1, 32'h0000_07fa);
		rd_ctx(1'b0, 32'h0000_0150);
		lazy_activate = 1'b1;
		@(negedge mclk);
		lazy_activate = 1'b0;
		rd_ctx(1'b1, 32'h0000_07ff);
		chk({31'h0, lazy_skip_memory}, 32'h1);
		chk({31'h0, lazy_zero_regs}, 32'h0);
		lazy_done = 1'b1;
		@(negedge mclk);
		lazy_done = 1'b0;
		rd_ctx(1'b1, 32'h0000_07fe);
		// treat-as-secure drives the derived outputs
		acc(1'b1, 2'h2, ctx_ctrl_addr, 32'h0400_0004, 1'b1, 1'b1, 1'b0);
		chk({29'h0, fp_regs_secure, push_callee_fp, lazy_zero_regs}, 32'h7);
		chk({31'h0, lazy_skip_memory}, 32'h0);
		cur_secure = 1'b0;
		fp_instr = 1'b1;
		@(negedge mclk);
		fp_instr = 1'b0;
		chk({30'h0, fp_regs_secure, push_callee_fp}, 32'h0);
		rd_ctx(1'b1, 32'h0400_0000);
		acc(1'b1, 2'h2, ctx_ctrl_addr, 32'h0, 1'b1, 1'b1, 1'b0);
		cur_secure = 1'b1;
		#1 chk({30'h0, fp_regs_secure, push_callee_fp}, 32'h0);
		// every rounding encoding reaches the status register on a new context
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, 2'h2, dflt_addr, {5'h0, m[0], 1'b1, m[1], m[1:0], 22'h0}, 1'b1, 1'b1, 1'b0);
			new_context_secure = 1'b1;
			new_context = 1'b1;
			@(negedge mclk);
			new_context = 1'b0;
			chk(fp_status_and_control, {5'h0, m[0], 1'b1, m[1], m[1:0], 22'h0});
		end
		new_context_secure = 1'b0;
		new_context = 1'b1;
		@(negedge mclk);
		new_context = 1'b0;
		chk(fp_status_and_control, 32'h0140_0000);
		// special register port: privilege gate, next-edge visibility
		sr_req = 1'b1;
		sr_write = 1'b1;
		sr_privileged = 1'b1;
		sr_wdata = 32'h1234_5678;
		@(negedge mclk);
		chk(fp_status_and_control, 32'h1234_5678);
		sr_privileged = 1'b0;
		sr_wdata = 32'hdead_beef;
		#1 chk(sr_rdata, 32'h0);
		@(negedge mclk);
		chk(fp_status_and_control, 32'h1234_5678);
		{sr_req, sr_write} = 2'h0;
		fpu_status_next = 32'h0000_009f;
		fpu_status_update = 1'b1;
		@(negedge mclk);
		fpu_status_update = 1'b0;
		sr_req = 1'b1;
		sr_privileged = 1'b1;
		#1 chk(sr_rdata, 32'h0000_009f);
		sr_req = 1'b0;
		// reset in mid-run restores documented values
		acc(1'b1, 2'h2, ctx_ctrl_addr, 32'h0400_0001, 1'b1, 1'b1, 1'b0);
		rstn = 1'b0;
		@(negedge mclk);
		rstn = 1'b1;
		chk(fp_status_and_control, 32'h0);
		rd_ctx(1'b1, 32'h0000_0004);
		acc(1'b0, 2'h2, dflt_addr, 32'h0, 1'b1, 1'b1, 1'b0);
		chk(rd, 32'h0);
		print_verdict;
	end
endmodule : tb_fp_context_control_regs
